// ### logic/gp8_port.sv
// Purpose: eight-pin general-purpose port with pull-ups, AXI4-Lite slave
// Assumes: standby entry and wake enables come from logic on aclk
// Notes: the read-modify-write view of the data register is its own alias
// Summary of operation
// - Direction bit one makes the pin an output port.
// - Direction bit zero makes the pin an input, driver off.
// - An output-port pin is driven from its data latch bit.
// - Data writes always update the latch; input pins show it later.
// - Ordinary read of an output pin returns the latch bit.
// - Ordinary read of input pin returns pin level; READ_MODIFY_WRITE_ACCESS read returns latch.
// - Peripheral output enable makes the peripheral drive the pin.
// - Peripheral-driven pin reads back the pin level; READ_MODIFY_WRITE_ACCESS read returns latch.
// - Peripheral input pins still read pin level; READ_MODIFY_WRITE_ACCESS read returns latch.
// - Reset clears every direction bit so all pins start as inputs.
// - Standby with isolate set floats pins and blocks inputs low.
// - Pins four and six stay unblocked when their wake interrupt is on.
// - Standby with isolate clear keeps pin states and output levels.
// - Pull-up bit one connects the resistor, zero disconnects it.
// - A pin driving low always has its pull-up disconnected.
// - Pull-up bit two is read/write but pin two has no pull-up.
// - Open-drain output with latch one floats instead of driving high.
// - Register bits zero to seven map onto pins zero to seven.
module gp8_port
    import gp8_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [PINS-1:0] pin_i,
    output logic [PINS-1:0] pin_o,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pullup_on,
    input wire logic [PINS-1:0] periph_oe,
    input wire logic [PINS-1:0] periph_out,
    output logic [PINS-1:0] periph_in,
    output logic [PINS-1:0] input_blocked,
    input wire logic standby_active,
    input wire logic wake_en_pin_four,
    input wire logic wake_en_pin_six
);
    // Software-visible state
    logic [7:0] port_output_latch_q;
    logic [7:0] port_direction_q;
    logic [7:0] port_pullup_enable_q;
    logic standby_pin_isolate_q;

    // Pin level synchroniser
    logic [PINS-1:0] pin_meta_q;
    logic [PINS-1:0] pin_sync_q;

    // Write channel holding
    logic aw_full_q;
    logic [ADDR_W-1:0] aw_addr_q;
    logic w_full_q;
    logic [7:0] w_data_q;
    logic w_lane0_q;
    logic bvalid_q;
    logic [1:0] bresp_q;
    logic wr_fire;
    logic wr_hit;

    // Read channel
    logic rvalid_q;
    logic [DATA_W-1:0] rdata_q;
    logic [1:0] rresp_q;
    logic rd_fire;

    // Pad-side results
    logic isolate;
    logic [PINS-1:0] wake_en;
    logic [PINS-1:0] cell_o;
    logic [PINS-1:0] cell_oe;
    logic [PINS-1:0] cell_pu;
    logic [PINS-1:0] cell_in;
    logic [PINS-1:0] cell_blk;
    logic [PINS-1:0] pin_o_q;
    logic [PINS-1:0] pin_oe_q;
    logic [PINS-1:0] pullup_q;
    logic [PINS-1:0] periph_in_q;
    logic [PINS-1:0] blocked_q;

    // Readback
    logic [7:0] data_view;
    logic [DATA_W-1:0] rd_word;
    logic rd_hit;

    // ---------------- Pin input synchroniser ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_q <= '0;
            pin_sync_q <= '0;
        end else begin
            pin_meta_q <= pin_i;
            pin_sync_q <= pin_meta_q;
        end
    end

    // ---------------- Write address / data capture ----------------
    // Each channel is held alone so either may arrive first
    assign s_axi_awready = ~aw_full_q;
    assign s_axi_wready = ~w_full_q;
    assign wr_fire = aw_full_q & w_full_q & ~bvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_full_q <= 1'b0;
            aw_addr_q <= '0;
        end else if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_full_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_full_q <= 1'b0;
            w_data_q <= '0;
            w_lane0_q <= 1'b0;
        end else if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata[7:0];
            w_lane0_q <= s_axi_wstrb[0];
        end else if (wr_fire) begin
            w_full_q <= 1'b0;
        end
    end

    always_comb begin
        case (aw_addr_q)
            OFS_LATCH, OFS_DIR, OFS_PULLUP, OFS_STANDBY, OFS_LATCH_RMW: wr_hit = 1'b1;
            OFS_STATUS: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    // ---------------- Write response ----------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q <= RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;

    // ---------------- Registers ----------------
    // Latch takes every data write, whatever the direction
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_output_latch_q <= RST_LATCH;
        end else if (wr_fire && w_lane0_q) begin
            if (aw_addr_q == OFS_LATCH || aw_addr_q == OFS_LATCH_RMW) begin
                port_output_latch_q <= w_data_q;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_direction_q <= RST_DIR;
        end else if (wr_fire && w_lane0_q && aw_addr_q == OFS_DIR) begin
            port_direction_q <= w_data_q;
        end
    end

    // Bit two stored like the rest; the cell ignores it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            port_pullup_enable_q <= RST_PULLUP;
        end else if (wr_fire && w_lane0_q && aw_addr_q == OFS_PULLUP) begin
            port_pullup_enable_q <= w_data_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            standby_pin_isolate_q <= RST_ISOLATE;
        end else if (wr_fire && w_lane0_q && aw_addr_q == OFS_STANDBY) begin
            standby_pin_isolate_q <= w_data_q[STBY_ISOLATE_BIT];
        end
    end

    // ---------------- Pin cells ----------------
    assign isolate = standby_active & standby_pin_isolate_q;

    always_comb begin
        wake_en = '0;
        wake_en[4] = wake_en_pin_four;
        wake_en[6] = wake_en_pin_six;
    end

    for (genvar i = 0; i < PINS; i++) begin : g_pin
        gp8_pin_cell #(
            .OPEN_DRAIN(OPEN_DRAIN_PINS[i]),
            .HAS_PULLUP(PULLUP_PRESENT[i]),
            .CAN_WAKE(WAKE_PINS[i])
        ) u_cell (
            .dir(port_direction_q[i]),
            .latch(port_output_latch_q[i]),
            .pullup_bit(port_pullup_enable_q[i]),
            .periph_oe(periph_oe[i]),
            .periph_out(periph_out[i]),
            .isolate(isolate),
            .wake_en(wake_en[i]),
            .pin_level(pin_sync_q[i]),
            .drive_o(cell_o[i]),
            .drive_oe(cell_oe[i]),
            .pullup_on(cell_pu[i]),
            .in_level(cell_in[i]),
            .blocked(cell_blk[i])
        );
    end

    // ---------------- Pad registers ----------------
    // Standby without isolation freezes the pads at their last state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_o_q <= '0;
            pin_oe_q <= '0;
            pullup_q <= '0;
        end else if (!standby_active || isolate) begin
            pin_o_q <= cell_o;
            pin_oe_q <= cell_oe;
            pullup_q <= cell_pu;
        end else begin
            pin_o_q <= pin_o_q;
            pin_oe_q <= pin_oe_q;
            pullup_q <= pullup_q;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            periph_in_q <= '0;
            blocked_q <= '0;
        end else begin
            periph_in_q <= cell_in;
            blocked_q <= cell_blk;
        end
    end

    assign pin_o = pin_o_q;
    assign pin_oe = pin_oe_q;
    assign pullup_on = pullup_q;
    assign periph_in = periph_in_q;
    assign input_blocked = blocked_q;

    // ---------------- Read path ----------------
    // Port-driven pins read the latch; inputs and peripheral pins the pad
    always_comb begin
        for (int i = 0; i < PINS; i++) begin
            if (port_direction_q[i] && !periph_oe[i]) begin
                data_view[i] = port_output_latch_q[i];
            end else begin
                data_view[i] = pin_sync_q[i];
            end
        end
    end

    always_comb begin
        rd_word = '0;
        rd_hit = 1'b1;
        case (s_axi_araddr)
            OFS_LATCH: rd_word[7:0] = data_view;
            OFS_LATCH_RMW: rd_word[7:0] = port_output_latch_q;
            OFS_DIR: rd_word[7:0] = port_direction_q;
            OFS_PULLUP: rd_word[7:0] = port_pullup_enable_q;
            OFS_STANDBY: rd_word[STBY_ISOLATE_BIT] = standby_pin_isolate_q;
            OFS_STATUS: begin
                rd_word[STAT_STANDBY_BIT] = standby_active;
                rd_word[STAT_ISOLATED_BIT] = isolate;
            end
            default: rd_hit = 1'b0;
        endcase
    end

    // One read in flight; the next address waits for rready
    assign s_axi_arready = ~rvalid_q;
    assign rd_fire = s_axi_arvalid & ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
        end else if (rd_fire) begin
            rvalid_q <= 1'b1;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rdata_q <= '0;
            rresp_q <= RESP_OKAY;
        end else if (rd_fire) begin
            rdata_q <= rd_word;
            rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata = rdata_q;
    assign s_axi_rresp = rresp_q;
endmodule

// ### logic/gp8_pkg.sv
// Purpose: constants shared by the eight-pin port and its pin cell
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes: open-drain and pull-up masks select per-pin build options
package gp8_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int PINS = 8;

    localparam logic [ADDR_W-1:0] OFS_LATCH = 8'h00;
    localparam logic [ADDR_W-1:0] OFS_DIR = 8'h04;
    localparam logic [ADDR_W-1:0] OFS_PULLUP = 8'h08;
    localparam logic [ADDR_W-1:0] OFS_STANDBY = 8'h0C;
    localparam logic [ADDR_W-1:0] OFS_LATCH_RMW = 8'h10;
    localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h14;

    localparam logic [7:0] RST_LATCH = 8'h00;
    localparam logic [7:0] RST_DIR = 8'h00;
    localparam logic [7:0] RST_PULLUP = 8'h00;
    localparam logic RST_ISOLATE = 1'b0;

    localparam int STBY_ISOLATE_BIT = 0;
    localparam int STAT_STANDBY_BIT = 0;
    localparam int STAT_ISOLATED_BIT = 1;

    // Pin two has no pull-up; pins four and six can wake the part
    localparam logic [7:0] PULLUP_PRESENT = 8'hFB;
    localparam logic [7:0] OPEN_DRAIN_PINS = 8'h00;
    localparam logic [7:0] WAKE_PINS = 8'h50;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ### logic/gp8_pin_cell.sv
// Purpose: pad-side logic of one port pin
// Assumes: all inputs on the bus clock; pin level already synchronised
// Notes: purely combinational, the top registers the results
module gp8_pin_cell
    import gp8_pkg::*;
#(
    parameter logic OPEN_DRAIN = 1'b0,
    parameter logic HAS_PULLUP = 1'b1,
    parameter logic CAN_WAKE = 1'b0
) (
    input wire logic dir,
    input wire logic latch,
    input wire logic pullup_bit,
    input wire logic periph_oe,
    input wire logic periph_out,
    input wire logic isolate,
    input wire logic wake_en,
    input wire logic pin_level,
    output logic drive_o,
    output logic drive_oe,
    output logic pullup_on,
    output logic in_level,
    output logic blocked
);
    logic drive_val;
    logic drive_req;

    always_comb begin
        drive_val = periph_oe ? periph_out : latch;
        drive_req = periph_oe | dir;
    end

    always_comb begin
        drive_o = drive_val;
        drive_oe = drive_req;
        if (OPEN_DRAIN && drive_val) begin
            drive_oe = 1'b0;
        end
        if (isolate) begin
            drive_oe = 1'b0;
        end
    end

    always_comb begin
        // Resistor off while pulling low, wasted current otherwise
        pullup_on = HAS_PULLUP & pullup_bit & ~(drive_oe & ~drive_o);
        blocked = isolate & ~(CAN_WAKE & wake_en);
        in_level = blocked ? 1'b0 : pin_level;
    end
endmodule

// ### tb/gp8_port_properties.sv
// Purpose: concurrent checks on the pin side of gp8_port
// Assumes: register writes are shadowed from the AXI channels
// Notes: shadow-based pin checks skip the one cycle in which a store lands
module gp8_port_checker
    import gp8_pkg::*;
(
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [DATA_W-1:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic [PINS-1:0] pin_o,
    input wire logic [PINS-1:0] pin_oe,
    input wire logic [PINS-1:0] pullup_on,
    input wire logic [PINS-1:0] periph_oe,
    input wire logic [PINS-1:0] periph_out,
    input wire logic [PINS-1:0] periph_in,
    input wire logic [PINS-1:0] input_blocked,
    input wire logic standby_active,
    input wire logic wake_en_pin_four,
    input wire logic wake_en_pin_six
);
    logic [7:0] a_q, d_q, lat_q, dir_q, pul_q, exp_oe, exp_o, wk;
    logic iso_q, bv_q, rst_q, ok, isol;
    logic upd, iso_v;
    logic [7:0] lat_v, dir_v, pul_v;
    always_ff @(posedge aclk) begin
        rst_q <= aresetn;
        bv_q <= s_axi_bvalid;
        if (s_axi_awvalid && s_axi_awready)
            a_q <= s_axi_awaddr;
        if (s_axi_wvalid && s_axi_wready)
            d_q <= s_axi_wdata[7:0];
    end
    // Shadow lags the design by one edge, hence the skipped cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lat_q <= 8'h00;
            dir_q <= 8'h00;
            pul_q <= 8'h00;
            iso_q <= 1'b0;
        end else if (s_axi_bvalid && !bv_q) begin
            case (a_q)
                OFS_LATCH, OFS_LATCH_RMW: lat_q <= d_q;
                OFS_DIR: dir_q <= d_q;
                OFS_PULLUP: pul_q <= d_q;
                OFS_STANDBY: iso_q <= d_q[0];
                default: ;
            endcase
        end
    end
    // Views show the store one edge early, in step with the design registers
    always_comb begin
        upd = s_axi_bvalid && !bv_q;
        lat_v = (upd && (a_q == OFS_LATCH || a_q == OFS_LATCH_RMW)) ? d_q : lat_q;
        dir_v = (upd && a_q == OFS_DIR) ? d_q : dir_q;
        pul_v = (upd && a_q == OFS_PULLUP) ? d_q : pul_q;
        iso_v = (upd && a_q == OFS_STANDBY) ? d_q[0] : iso_q;
    end
    assign exp_oe = periph_oe | dir_v;
    assign exp_o = (periph_oe & periph_out) | (~periph_oe & lat_v);
    assign wk = {1'b0, wake_en_pin_six, 1'b0, wake_en_pin_four, 4'h0} & WAKE_PINS;
    assign ok = rst_q && !upd;
    assign isol = standby_active && iso_v;
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_run;
        ok && !$past(standby_active);
    endsequence
    sequence s_iso;
        ok && $past(isol);
    endsequence
    a_port_enable: assert property (s_run |-> pin_oe == $past(exp_oe))
        else $error("pin enable wrong");
    a_port_value: assert property (s_run |-> (pin_o & pin_oe) == ($past(exp_o) & pin_oe))
        else $error("pin value wrong");
    a_pull_follow: assert property (s_run |->
        pullup_on == $past(pul_v & PULLUP_PRESENT & ~(exp_oe & ~exp_o)))
        else $error("pull-up state wrong");
    a_iso_float: assert property (s_iso |-> pin_oe == 8'h00 && (periph_in & input_blocked) == 8'h00)
        else $error("isolated pin not floating");
    a_wake_pass: assert property (s_iso |-> input_blocked == ~$past(wk))
        else $error("wake pin blocking wrong");
    a_hold_level: assert property (ok && $past(standby_active && !iso_v) |->
        $stable(pin_oe) && $stable(pin_o))
        else $error("pins moved in standby");
    a_pull_low_off: assert property ((pullup_on & pin_oe & ~pin_o) == 8'h00)
        else $error("pull-up on a low pin");
    a_pull_two_off: assert property (!pullup_on[2])
        else $error("pin two pull-up on");
    a_reset_clear: assert property (disable iff (1'b0) !aresetn |=>
        pin_oe == 8'h00 && pullup_on == 8'h00)
        else $error("reset left pins active");
endmodule
bind gp8_port gp8_port_checker u_chk (.*);

// ### tb/gp8_board_model.sv
// Purpose: board side of the eight pins
// Assumes: the bench avoids driving a pin that the port drives
// Notes: an undriven pin without pull-up toggles, never holds
module gp8_board_model (
    input wire logic aclk,
    input wire logic [7:0] pin_o,
    input wire logic [7:0] pin_oe,
    input wire logic [7:0] pullup_on,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pin_lvl
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] last_q = 8'h00;
    always_ff @(posedge aclk)
        last_q <= pin_lvl;
    assign pin_lvl = (pin_oe & pin_o) | (~pin_oe & ext_en & ext_val)
        | (~pin_oe & ~ext_en & (pullup_on | ~last_q));
endmodule

// ### tb/tb.sv
// Purpose: self-checking bench for gp8_port
// Assumes: AXI4-Lite master tasks, board model on the pins
// Notes: random values from an LFSR seeded with 74
module tb;
    import gp8_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic aclk = 0, aresetn = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata, rdv;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
    logic [7:0] pin_i, pin_o, pin_oe, pullup_on, periph_in, input_blocked;
    logic [7:0] periph_oe = 0, periph_out = 0, ext_en = 0, ext_val = 0;
    logic standby_active = 0, wake_en_pin_four = 0, wake_en_pin_six = 0;
    logic [7:0] rnd = 8'h4A, d, l, x, p;
    int n_errors = 0, n_checks = 0;
    always #12.5 aclk = ~aclk;
    gp8_port dut (.*);
    gp8_board_model u_board (.aclk, .pin_o, .pin_oe, .pullup_on, .ext_en, .ext_val,
        .pin_lvl(pin_i));
    function automatic logic [7:0] nxt(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    function automatic logic [7:0] rd_exp(input logic [7:0] dr, lt, pn, po);
        return (lt & dr & ~po) | (pn & ~(dr & ~po));
    endfunction
    function automatic logic [7:0] pull_exp(input logic [7:0] pu, dr, lt);
        return pu & PULLUP_PRESENT & ~(dr & ~lt);
    endfunction
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask
    // Readies and answers are sampled at the falling edge, where they are settled
    task automatic wr(input logic [7:0] a, input logic [7:0] dv);
        logic aw_t, w_t, b_t;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, dv};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(negedge aclk);
            aw_t = s_axi_awready;
            w_t = s_axi_wready;
            b_t = s_axi_bvalid;
            rsp = s_axi_bresp;
            @(posedge aclk);
            if (aw_t) s_axi_awvalid <= 1'b0;
            if (w_t) s_axi_wvalid <= 1'b0;
        end while (!b_t);
        s_axi_bready <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string nm);
        logic ar_t, r_t;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(negedge aclk);
            ar_t = s_axi_arready;
            r_t = s_axi_rvalid;
            rdv = s_axi_rdata;
            rsp = s_axi_rresp;
            @(posedge aclk);
            if (ar_t) s_axi_arvalid <= 1'b0;
        end while (!r_t);
        s_axi_rready <= 1'b0;
        chk(nm, {24'h0, e}, rdv);
    endtask
    task automatic end_sim;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge aclk);
        n_errors++;
        end_sim();
    end
    initial begin
        repeat (8) @(posedge aclk);
        aresetn <= 1'b1;
        rdc(OFS_DIR, RST_DIR, "dir reset");
        rdc(OFS_LATCH_RMW, 8'h00, "latch reset");
        rdc(OFS_PULLUP, 8'h00, "pull reset");
        rdc(8'h18, 8'h00, "unmapped read");
        chk("rresp", RESP_SLVERR, rsp);
        wr(8'h18, 8'hFF);
        chk("bresp", RESP_SLVERR, rsp);
        for (int i = 0; i < 10; i++) begin
            rnd = nxt(rnd); d = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : rnd;
            rnd = nxt(rnd); l = (i == 2) ? 8'h00 : rnd;
            rnd = nxt(rnd); x = rnd;
            rnd = nxt(rnd); p = (i == 2) ? 8'hFF : rnd;
            ext_en <= ~d;
            ext_val <= x;
            wr(OFS_LATCH, l);
            wr(OFS_DIR, d);
            wr(OFS_PULLUP, p);
            repeat (4) @(posedge aclk);
            chk("pin_oe", d, pin_oe);
            chk("pin_o", l & d, pin_o & d);
            chk("pullup_on", pull_exp(p, d, l), pullup_on);
            rdc(OFS_LATCH, rd_exp(d, l, x, 8'h00), "data read");
            rdc(OFS_LATCH_RMW, l, "rmw read");
            rdc(OFS_PULLUP, p, "pull reg");
        end
        rnd = nxt(rnd);
        wr(OFS_DIR, 8'h00);
        periph_oe <= rnd;
        periph_out <= x;
        ext_en <= ~rnd;
        ext_val <= ~x;
        repeat (4) @(posedge aclk);
        chk("periph oe", rnd, pin_oe);
        chk("periph out", x & rnd, pin_o & rnd);
        rdc(OFS_LATCH, rd_exp(8'h00, l, (x & rnd) | (~x & ~rnd), 8'h00), "periph rd");
        rdc(OFS_LATCH_RMW, l, "periph rmw");
        periph_oe <= 8'h00;
        ext_en <= 8'h00;
        wr(OFS_DIR, 8'hFF);
        wr(OFS_STANDBY, 8'h01);
        for (int k = 0; k < 4; k++) begin
            wake_en_pin_four <= k[0];
            wake_en_pin_six <= k[1];
            standby_active <= 1'b1;
            repeat (3) @(posedge aclk);
            chk("iso oe", 8'h00, pin_oe);
            chk("blocked", 8'(~{1'b0, k[1], 1'b0, k[0], 4'h0}), input_blocked);
            chk("iso input", 8'h00, periph_in & input_blocked);
        end
        rdc(OFS_STATUS, 8'h03, "status");
        standby_active <= 1'b0;
        wr(OFS_STANDBY, 8'h00);
        wr(OFS_LATCH, 8'hA5);
        standby_active <= 1'b1;
        wr(OFS_LATCH, 8'h5A);
        repeat (3) @(posedge aclk);
        chk("held level", 8'hA5, pin_o);
        chk("held oe", 8'hFF, pin_oe);
        standby_active <= 1'b0;
        repeat (3) @(posedge aclk);
        chk("resumed", 8'h5A, pin_o);
        end_sim();
    end
endmodule
